// File: design/rspt_top.v
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "rspt_map.vh"

// Contract
// - Three reset levels: power-on, hardware, software.
// - Short pad press gives hardware, long gives power-on.
// - Reset pad is always active high.
// - Software reset is control bit OR CPU request.
// - Reboot-after-sleep bit forces hardware reset on wake.
// - Power-on and hardware resets start cold start.
// - Three register reset domains by reset level.
// - Delay factor is seven bits, maximum all ones.
// - Delay is factor times 4096 slow periods.
// - Any asserted source forces slow oscillator on.
// - Pad start uses default trim, GPIO keeps programmed.
// - Selected GPIO still works as ordinary GPIO.
// - Pin select holds pin; zero disables.
// - Polarity bit: zero active low, one high.
// - Timer counts while asserted, clears on release.
// - Overlapping sources accumulate toward the delay.
// - Pad expiry once per press; GPIO unrestricted.
// - Pin select cleared by all; factor by power-on.
// - Cause of the latest reset is latched.
module rspt_top (
	input wire i_clock,
	input wire i_rst_n,
	input wire i_clk_en,
	input wire i_reset_pad_pin,
	input wire [`RSPT_GPIO_N-1:0] i_gpio,
	input wire i_slow_rc_oscillator,
	input wire i_cpu_reset_req,
	input wire i_wake_from_sleep,
	input wire [`RSPT_ADDR_W-1:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] i_avs_writedata,
	input wire [3:0] i_avs_byteenable,
	output reg [31:0] o_avs_readdata,
	output reg o_avs_waitrequest,
	output reg o_por_reset,
	output reg o_hw_reset,
	output reg o_software_reboot_bit,
	output reg o_domain_por_only,
	output reg o_domain_por_hw,
	output reg o_domain_all,
	output reg o_cold_start,
	output reg o_slow_osc_enable,
	output reg o_slow_osc_default_trim
);
	// ------------------------------------------------------------------
	// Constants
	// ------------------------------------------------------------------
	localparam integer HOLD_CYC_I =
		(`RSPT_HOLD_NS * 1000 + `RSPT_CLK_PERIOD_PS - 1) /
		`RSPT_CLK_PERIOD_PS;
	localparam [7:0] HOLD_CYC = HOLD_CYC_I[7:0];
	localparam [7:0] HOLD_LAST = HOLD_CYC - 8'h01;

	localparam ST_IDLE = 1'b0;
	localparam ST_HOLD = 1'b1;

	localparam [1:0] CAUSE_NONE = 2'h0;
	localparam [1:0] CAUSE_SW = 2'h1;
	localparam [1:0] CAUSE_HW = 2'h2;
	localparam [1:0] CAUSE_POR = 2'h3;

	// Byte-lane merge shared by every writable register.
	function [31:0] merge_word;
		input [31:0] old_word;
		input [31:0] new_word;
		input [3:0] be;
		integer k;
		begin
			merge_word = old_word;
			for (k = 0; k < 4; k = k + 1) begin
				if (be[k]) begin
					merge_word[k*8 +: 8] = new_word[k*8 +: 8];
				end
			end
		end
	endfunction

	// ------------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------------
	wire [`RSPT_GPIO_N+1:0] sync_q;
	wire pad_s;
	wire slow_s;
	wire [`RSPT_GPIO_N-1:0] gpio_s;

	rspt_sync #(
		.W(`RSPT_GPIO_N + 2)
	) u_sync (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_d({i_slow_rc_oscillator, i_gpio, i_reset_pad_pin}),
		.o_q(sync_q)
	);

	assign pad_s = sync_q[0];
	assign gpio_s = sync_q[`RSPT_GPIO_N:1];
	assign slow_s = sync_q[`RSPT_GPIO_N+1];

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	reg [`RSPT_FACTOR_W-1:0] factor;
	reg [`RSPT_PIN_W-1:0] pin_sel;
	reg pin_pol;
	reg swrb;
	reg ras;
	reg osc_sw_en;
	reg [2:0] stat;

	reg slow_d;
	reg pad_d;
	reg pad_lock;
	reg run_d;
	reg start_by_pad;
	reg state;
	reg [1:0] cause;
	reg [7:0] hold_cnt;

	wire tick;
	wire gpio_hit;
	wire pad_count;
	wire run;
	wire expire;
	wire [`RSPT_FACTOR_W-1:0] steps;
	wire pad_short;
	wire por_req;
	wire hw_req;
	wire sw_req;

	assign tick = slow_s & ~slow_d;

	// The GPIO is only observed here; the pin keeps its normal function.
	assign gpio_hit = (pin_sel != `RSPT_PIN_SEL_OFF) &&
		(pin_sel < `RSPT_GPIO_N) &&
		(gpio_s[pin_sel] == pin_pol);

	assign pad_count = pad_s & ~pad_lock;
	assign run = pad_count | gpio_hit;

	rspt_timer u_timer (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_tick(tick),
		.i_run(run),
		.i_factor(factor),
		.o_expire(expire),
		.o_steps(steps)
	);

	// ------------------------------------------------------------------
	// Reset requests
	// ------------------------------------------------------------------
	assign pad_short = pad_d & ~pad_s & ~pad_lock;
	assign por_req = expire;
	assign hw_req = pad_short | (i_wake_from_sleep & ras);
	assign sw_req = swrb | i_cpu_reset_req;

	reg [1:0] req_cause;
	reg next_state;
	reg [1:0] next_cause;
	reg [7:0] next_hold;
	reg issue;

	always @* begin
		if (por_req) begin
			req_cause = CAUSE_POR;
		end else if (hw_req) begin
			req_cause = CAUSE_HW;
		end else if (sw_req) begin
			req_cause = CAUSE_SW;
		end else begin
			req_cause = CAUSE_NONE;
		end
		next_state = state;
		next_cause = cause;
		next_hold = hold_cnt;
		issue = 1'b0;
		case (state)
			ST_IDLE: begin
				if (req_cause != CAUSE_NONE) begin
					issue = 1'b1;
					next_state = ST_HOLD;
					next_cause = req_cause;
					next_hold = HOLD_LAST;
				end
			end
			ST_HOLD: begin
				// A stronger request during a hold upgrades and restarts it.
				if (req_cause > cause) begin
					issue = 1'b1;
					next_cause = req_cause;
					next_hold = HOLD_LAST;
				end else if (hold_cnt == 8'h00) begin
					next_state = ST_IDLE;
					next_cause = CAUSE_NONE;
				end else begin
					next_hold = hold_cnt - 8'h01;
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_cause = CAUSE_NONE;
				next_hold = 8'h00;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Sequencing state and outputs
	// ------------------------------------------------------------------
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			slow_d <= 1'b0;
			pad_d <= 1'b0;
			pad_lock <= 1'b0;
			run_d <= 1'b0;
			start_by_pad <= 1'b0;
			state <= ST_IDLE;
			cause <= CAUSE_NONE;
			hold_cnt <= 8'h00;
			o_por_reset <= 1'b0;
			o_hw_reset <= 1'b0;
			o_software_reboot_bit <= 1'b0;
			o_domain_por_only <= 1'b0;
			o_domain_por_hw <= 1'b0;
			o_domain_all <= 1'b0;
			o_cold_start <= 1'b0;
			o_slow_osc_enable <= 1'b1;
			o_slow_osc_default_trim <= 1'b0;
		end else if (i_clk_en) begin
			slow_d <= slow_s;
			pad_d <= pad_s;
			run_d <= run;
			// Lock survives the reset it causes; only release unlocks.
			if (!pad_s) begin
				pad_lock <= 1'b0;
			end else if (expire) begin
				pad_lock <= 1'b1;
			end
			if (run & ~run_d) begin
				start_by_pad <= pad_count;
			end
			state <= next_state;
			cause <= next_cause;
			hold_cnt <= next_hold;
			o_por_reset <= (next_cause == CAUSE_POR);
			o_hw_reset <= (next_cause == CAUSE_HW);
			o_software_reboot_bit <= (next_cause == CAUSE_SW);
			o_domain_por_only <= (next_cause == CAUSE_POR);
			o_domain_por_hw <= (next_cause >= CAUSE_HW);
			o_domain_all <= (next_cause != CAUSE_NONE);
			o_cold_start <= issue & (req_cause >= CAUSE_HW);
			o_slow_osc_enable <= osc_sw_en | pad_s | gpio_hit;
			o_slow_osc_default_trim <= run & start_by_pad;
		end
	end

	// ------------------------------------------------------------------
	// Avalon-MM slave
	// ------------------------------------------------------------------
	wire wr_go;
	wire [31:0] wr_word;
	reg [31:0] rd_word;

	assign wr_go = i_avs_write & ~o_avs_waitrequest;

	always @* begin
		rd_word = 32'h0000_0000;
		case (i_avs_address)
			`RSPT_OFS_TIMER: rd_word[`RSPT_FACTOR_W-1:0] = factor;
			`RSPT_OFS_PIN: begin
				rd_word[`RSPT_PIN_W-1:0] = pin_sel;
				rd_word[`RSPT_PIN_POL_BIT] = pin_pol;
			end
			`RSPT_OFS_SYSCTL: rd_word[`RSPT_SYS_SWRB_BIT] = swrb;
			`RSPT_OFS_PWRCTL: begin
				rd_word[`RSPT_PWR_RAS_BIT] = ras;
				rd_word[`RSPT_PWR_OSC_BIT] = osc_sw_en;
			end
			`RSPT_OFS_STAT: rd_word[2:0] = stat;
			`RSPT_OFS_TSTAT: begin
				rd_word[`RSPT_FACTOR_W-1:0] = steps;
				rd_word[8] = run;
				rd_word[9] = pad_lock;
				rd_word[10] = gpio_hit;
				rd_word[11] = pad_s;
			end
			default: rd_word = 32'h0000_0000;
		endcase
	end

	function [31:0] reg_word;
		input [31:0] old_word;
		begin
			reg_word = merge_word(old_word, i_avs_writedata, i_avs_byteenable);
		end
	endfunction

	assign wr_word = reg_word(rd_word);

	// Each access waits exactly one cycle; the reply is registered.
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata <= 32'h0000_0000;
		end else if (i_clk_en) begin
			if ((i_avs_read | i_avs_write) & o_avs_waitrequest) begin
				o_avs_waitrequest <= 1'b0;
				if (i_avs_read) begin
					o_avs_readdata <= rd_word;
				end
			end else begin
				o_avs_waitrequest <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Register file with its reset domains
	// ------------------------------------------------------------------
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			factor <= `RSPT_FACTOR_RST;
			pin_sel <= `RSPT_PIN_SEL_OFF;
			pin_pol <= 1'b0;
			swrb <= 1'b0;
			ras <= 1'b0;
			osc_sw_en <= 1'b1;
			stat <= `RSPT_STAT_RST;
		end else if (i_clk_en) begin
			if (wr_go) begin
				case (i_avs_address)
					`RSPT_OFS_TIMER:
						factor <= wr_word[`RSPT_FACTOR_W-1:0];
					`RSPT_OFS_PIN: begin
						pin_sel <= wr_word[`RSPT_PIN_W-1:0];
						pin_pol <= wr_word[`RSPT_PIN_POL_BIT];
					end
					`RSPT_OFS_SYSCTL: swrb <= wr_word[`RSPT_SYS_SWRB_BIT];
					`RSPT_OFS_PWRCTL: begin
						ras <= wr_word[`RSPT_PWR_RAS_BIT];
						osc_sw_en <= wr_word[`RSPT_PWR_OSC_BIT];
					end
					`RSPT_OFS_STAT: stat <= stat & ~wr_word[2:0];
					default: begin
					end
				endcase
			end
			// Reset effects come last so that they win over a bus write.
			if (issue) begin
				stat <= 3'h0;
				stat[`RSPT_STAT_POR_BIT] <= (req_cause == CAUSE_POR);
				stat[`RSPT_STAT_HW_BIT] <= (req_cause == CAUSE_HW);
				stat[`RSPT_STAT_SW_BIT] <= (req_cause == CAUSE_SW);
				pin_sel <= `RSPT_PIN_SEL_OFF;
				swrb <= 1'b0;
				if (req_cause >= CAUSE_HW) begin
					ras <= 1'b0;
					osc_sw_en <= 1'b1;
				end
				if (req_cause == CAUSE_POR) begin
					factor <= `RSPT_FACTOR_RST;
					pin_pol <= 1'b0;
				end
			end
		end
	end
endmodule

// File: design/rspt_map.vh
`ifndef RSPT_MAP_VH
`define RSPT_MAP_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------------
`define RSPT_ADDR_W 8
`define RSPT_OFS_TIMER 8'h00
`define RSPT_OFS_PIN 8'h04
`define RSPT_OFS_SYSCTL 8'h08
`define RSPT_OFS_PWRCTL 8'h0C
`define RSPT_OFS_STAT 8'h10
`define RSPT_OFS_TSTAT 8'h14

// ----------------------------------------------------------------------
// Field layouts and reset values
// ----------------------------------------------------------------------
`define RSPT_FACTOR_W 7
`define RSPT_FACTOR_MAX 7'h7F
`define RSPT_FACTOR_RST 7'h18
`define RSPT_PRESCALE_W 12
`define RSPT_PRESCALE_LAST 12'hFFF
`define RSPT_PIN_W 4
`define RSPT_GPIO_N 12
`define RSPT_PIN_SEL_OFF 4'h0
`define RSPT_PIN_POL_BIT 4
`define RSPT_SYS_SWRB_BIT 0
`define RSPT_PWR_RAS_BIT 0
`define RSPT_PWR_OSC_BIT 1
`define RSPT_STAT_POR_BIT 0
`define RSPT_STAT_HW_BIT 1
`define RSPT_STAT_SW_BIT 2
`define RSPT_STAT_RST 3'h1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RSPT_CLK_PERIOD_PS 4000
`define RSPT_HOLD_NS 100

`endif

// File: design/rspt_sync.v
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Two-stage synchroniser for pin-level inputs
// ----------------------------------------------------------------------
module rspt_sync #(
	parameter W = 1
) (
	input wire i_clock,
	input wire i_rst_n,
	input wire i_clk_en,
	input wire [W-1:0] i_d,
	output reg [W-1:0] o_q
);
	reg [W-1:0] meta;

	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta <= {W{1'b0}};
			o_q <= {W{1'b0}};
		end else if (i_clk_en) begin
			meta <= i_d;
			o_q <= meta;
		end
	end
endmodule

// File: design/rspt_timer.v
`timescale 1ns/1ps
`include "rspt_map.vh"

// ----------------------------------------------------------------------
// Reset-hold timer: 4096-tick prescaler and step counter
// ----------------------------------------------------------------------
module rspt_timer (
	input wire i_clock,
	input wire i_rst_n,
	input wire i_clk_en,
	input wire i_tick,
	input wire i_run,
	input wire [`RSPT_FACTOR_W-1:0] i_factor,
	output reg o_expire,
	output wire [`RSPT_FACTOR_W-1:0] o_steps
);
	reg [`RSPT_PRESCALE_W-1:0] prescale;
	reg [`RSPT_FACTOR_W-1:0] steps;
	wire [`RSPT_FACTOR_W:0] steps_inc;

	assign steps_inc = {1'b0, steps} + {{`RSPT_FACTOR_W{1'b0}}, 1'b1};
	assign o_steps = steps;

	// A factor of zero never matches, so the timer never expires.
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prescale <= {`RSPT_PRESCALE_W{1'b0}};
			steps <= {`RSPT_FACTOR_W{1'b0}};
			o_expire <= 1'b0;
		end else if (i_clk_en) begin
			o_expire <= 1'b0;
			if (!i_run) begin
				prescale <= {`RSPT_PRESCALE_W{1'b0}};
				steps <= {`RSPT_FACTOR_W{1'b0}};
			end else if (i_tick) begin
				if (prescale == `RSPT_PRESCALE_LAST) begin
					prescale <= {`RSPT_PRESCALE_W{1'b0}};
					if (steps_inc == {1'b0, i_factor}) begin
						o_expire <= 1'b1;
						steps <= {`RSPT_FACTOR_W{1'b0}};
					end else begin
						steps <= steps_inc[`RSPT_FACTOR_W-1:0];
					end
				end else begin
					prescale <= prescale + {{(`RSPT_PRESCALE_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule

// File: bench/rspt_monitor.sv
`timescale 1ns/1ps
`include "rspt_map.vh"

// ------
// Reset output and bus checks
// ------
module rspt_monitor (
	input wire i_clock,
	input wire i_rst_n,
	input wire i_clk_en,
	input wire i_reset_pad_pin,
	input wire i_cpu_reset_req,
	input wire [`RSPT_ADDR_W-1:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] o_avs_readdata,
	input wire o_avs_waitrequest,
	input wire o_por_reset,
	input wire o_hw_reset,
	input wire o_software_reboot_bit,
	input wire o_domain_por_only,
	input wire o_domain_por_hw,
	input wire o_domain_all,
	input wire o_cold_start,
	input wire o_slow_osc_enable,
	input wire o_slow_osc_default_trim
);
	reg [5:0] run_len;

	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	// Saturates so that a long upgraded hold cannot wrap to a small count.
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			run_len <= 6'h00;
		else if (!o_domain_all)
			run_len <= 6'h00;
		else if (run_len != 6'h3F)
			run_len <= run_len + 6'h01;
	end

	sequence cold_s;
		o_cold_start ##1 !o_cold_start;
	endsequence
	sequence bus_req_s;
		(i_avs_read || i_avs_write) && o_avs_waitrequest && i_clk_en;
	endsequence

	chk_one_level: assert property (
		$onehot0({o_por_reset, o_hw_reset, o_software_reboot_bit}))
		else $error("more than one reset level high");
	chk_domain_map: assert property (
		o_domain_por_only == o_por_reset &&
		o_domain_por_hw == (o_por_reset || o_hw_reset) &&
		o_domain_all == (o_domain_por_hw || o_software_reboot_bit))
		else $error("reset domain outputs disagree with levels");
	chk_cold_pulse: assert property (
		($rose(o_por_reset) || $rose(o_hw_reset)) |-> cold_s)
		else $error("cold start pulse missing");
	chk_cold_cause: assert property (
		o_cold_start |-> o_domain_por_hw)
		else $error("cold start without power-on or hardware reset");
	chk_hold_time: assert property (
		$fell(o_domain_all) |-> run_len >= 6'h19)
		else $error("reset released too early");
	chk_pad_osc: assert property (
		i_reset_pad_pin [*5] |-> o_slow_osc_enable)
		else $error("slow oscillator off while pad held");
	chk_trim_osc: assert property (
		o_slow_osc_default_trim |-> o_slow_osc_enable)
		else $error("default trim without oscillator");
	chk_sw_issue: assert property (
		i_cpu_reset_req && !o_domain_all |-> ##[1:2] o_domain_all)
		else $error("cpu request gave no reset");
	chk_wait_answer: assert property (
		bus_req_s |-> ##[1:2] !o_avs_waitrequest)
		else $error("bus request not answered");
	chk_wait_pulse: assert property (
		$fell(o_avs_waitrequest) |=> o_avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	chk_unmapped_zero: assert property (
		i_avs_read && !o_avs_waitrequest &&
		i_avs_address > `RSPT_OFS_TSTAT |-> o_avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
endmodule

bind rspt_top rspt_monitor rspt_monitor_inst (.i_clock, .i_rst_n, .i_clk_en,
	.i_reset_pad_pin, .i_cpu_reset_req, .i_avs_address, .i_avs_read,
	.i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .o_por_reset,
	.o_hw_reset, .o_software_reboot_bit, .o_domain_por_only, .o_domain_por_hw,
	.o_domain_all, .o_cold_start, .o_slow_osc_enable,
	.o_slow_osc_default_trim);

// File: bench/rspt_button.sv
`timescale 1ns/1ps

// ------
// Button on the reset pad
// ------
module rspt_button (
	input wire i_clock,
	output logic o_pad
);
	// The pad has a pull-down, so a released button reads low.
	initial o_pad = 1'b0;

	task press(input logic lvl);
		@(posedge i_clock);
		o_pad <= lvl;
	endtask
endmodule

// File: bench/rspt_top_bench.sv
`timescale 1ns/1ps
`include "rspt_map.vh"

module rspt_top_bench;
	logic i_clock, i_rst_n, i_slow_rc_oscillator;
	logic i_cpu_reset_req, i_wake_from_sleep, i_avs_read, i_avs_write;
	logic i_clk_en;
	logic [3:0] i_avs_byteenable;
	logic [11:0] i_gpio;
	logic [7:0] i_avs_address;
	logic [31:0] i_avs_writedata, q;
	wire i_reset_pad_pin, o_avs_waitrequest, o_por_reset, o_hw_reset;
	wire o_software_reboot_bit, o_domain_por_only, o_domain_por_hw, o_domain_all;
	wire o_cold_start, o_slow_osc_enable, o_slow_osc_default_trim;
	wire [31:0] o_avs_readdata;
	logic [1:0] sdiv;
	int err_total, checked, n;
	logic [7:0] adr [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
	logic [7:0] rv [6] = '{8'h18, 8'h00, 8'h00, 8'h02, 8'h01, 8'h00};

	rspt_top rspt_top_inst (.i_clock, .i_rst_n, .i_clk_en,
		.i_reset_pad_pin, .i_gpio, .i_slow_rc_oscillator, .i_cpu_reset_req,
		.i_wake_from_sleep, .i_avs_address, .i_avs_read, .i_avs_write,
		.i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
		.o_avs_waitrequest, .o_por_reset, .o_hw_reset, .o_software_reboot_bit,
		.o_domain_por_only, .o_domain_por_hw, .o_domain_all, .o_cold_start,
		.o_slow_osc_enable, .o_slow_osc_default_trim);
	rspt_button rspt_button_inst (.i_clock, .o_pad(i_reset_pad_pin));

	initial begin
		i_clock = 1'b0;
		forever #2 i_clock = ~i_clock;
	end

	// A slow period of 8 clocks keeps one 4096-tick step near 33k cycles.
	always @(posedge i_clock) begin
		sdiv <= sdiv + 2'h1;
		if (sdiv == 2'h3)
			i_slow_rc_oscillator <= ~i_slow_rc_oscillator;
	end

	// ------
	// Tasks
	// ------
	task check(input string nm, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task complete_run;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge i_clock);
		i_avs_address <= a;
		i_avs_write <= w;
		i_avs_read <= !w;
		i_avs_writedata <= d;
		@(posedge i_clock);
		while (o_avs_waitrequest !== 1'b0) begin
			k++;
			if (k > 50) begin
				err_total++;
				complete_run;
			end
			@(posedge i_clock);
		end
		q = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus(1'b0, a, 32'h0000_0000);
		check(nm, q, e);
	endtask

	task expect_rst(input logic [2:0] e, input int lim);
		n = 0;
		while (o_domain_all !== 1'b1) begin
			n++;
			if (n > lim) begin
				err_total++;
				complete_run;
			end
			@(posedge i_clock);
		end
		check("reset level", {o_por_reset, o_hw_reset, o_software_reboot_bit}, e);
		repeat (30) @(posedge i_clock);
		check("reset released", o_domain_all, 1'b0);
	endtask

	task quiet(input int c);
		logic seen;
		seen = 1'b0;
		repeat (c) begin
			@(posedge i_clock);
			seen = seen | o_domain_all;
		end
		check("no reset", seen, 1'b0);
	endtask

	task pulse(input logic w);
		@(posedge i_clock);
		if (w)
			i_wake_from_sleep <= 1'b1;
		else
			i_cpu_reset_req <= 1'b1;
		@(posedge i_clock);
		i_wake_from_sleep <= 1'b0;
		i_cpu_reset_req <= 1'b0;
	endtask

	// ------
	// Sequence
	// ------
	initial begin
		i_rst_n = 1'b0;
		i_slow_rc_oscillator = 1'b0;
		sdiv = 2'h0;
		i_cpu_reset_req = 1'b0;
		i_wake_from_sleep = 1'b0;
		i_avs_read = 1'b0;
		i_avs_write = 1'b0;
		i_avs_address = 8'h00;
		i_avs_writedata = 32'h0000_0000;
		i_gpio = 12'h000;
		i_clk_en = 1'b1;
		i_avs_byteenable = 4'hF;
		repeat (6) @(posedge i_clock);
		i_rst_n <= 1'b1;
		for (int i = 0; i < 6; i++)
			rd(adr[i], rv[i], "reset value");
		bus(1'b1, `RSPT_OFS_TIMER, 32'hFFFF_FFFF);
		rd(`RSPT_OFS_TIMER, 8'h7F, "factor max");
		// A masked low lane must leave the delay factor untouched.
		i_avs_byteenable <= 4'hE;
		bus(1'b1, `RSPT_OFS_TIMER, 32'h0000_0001);
		i_avs_byteenable <= 4'hF;
		rd(`RSPT_OFS_TIMER, 8'h7F, "lane masked");
		bus(1'b1, `RSPT_OFS_TIMER, 32'h0000_0001);
		bus(1'b1, `RSPT_OFS_PIN, 32'h0000_0013);
		rspt_button_inst.press(1'b1);
		repeat (200) @(posedge i_clock);
		rspt_button_inst.press(1'b0);
		expect_rst(3'b010, 60);
		rd(`RSPT_OFS_STAT, 8'h02, "cause");
		rd(`RSPT_OFS_PIN, 8'h10, "pin select");
		rd(`RSPT_OFS_TIMER, 8'h01, "factor kept");
		bus(1'b1, `RSPT_OFS_PIN, 32'h0000_0013);
		bus(1'b1, `RSPT_OFS_SYSCTL, 32'h0000_0001);
		expect_rst(3'b001, 60);
		rd(`RSPT_OFS_SYSCTL, 8'h00, "sw bit");
		rd(`RSPT_OFS_PIN, 8'h10, "pin select");
		rd(`RSPT_OFS_STAT, 8'h04, "cause");
		pulse(1'b0);
		// A low clock enable must freeze the hold window mid-way.
		repeat (4) @(posedge i_clock);
		i_clk_en <= 1'b0;
		repeat (40) @(posedge i_clock);
		check("frozen hold", o_software_reboot_bit, 1'b1);
		i_clk_en <= 1'b1;
		expect_rst(3'b001, 60);
		pulse(1'b1);
		quiet(60);
		bus(1'b1, `RSPT_OFS_PWRCTL, 32'h0000_0003);
		pulse(1'b1);
		expect_rst(3'b010, 60);
		rd(`RSPT_OFS_PWRCTL, 8'h02, "power control");
		bus(1'b1, `RSPT_OFS_STAT, 32'h0000_0002);
		rd(`RSPT_OFS_STAT, 8'h00, "cause cleared");
		@(posedge i_clock);
		i_gpio <= 12'hFFF;
		bus(1'b1, `RSPT_OFS_PIN, 32'h0000_0005);
		bus(1'b0, `RSPT_OFS_TSTAT, 32'h0000_0000);
		check("gpio idle", q[10], 1'b0);
		i_gpio <= 12'hFDF;
		repeat (10) @(posedge i_clock);
		bus(1'b0, `RSPT_OFS_TSTAT, 32'h0000_0000);
		check("gpio low active", q[10], 1'b1);
		check("gpio trim", o_slow_osc_default_trim, 1'b0);
		bus(1'b1, `RSPT_OFS_PIN, 32'h0000_0000);
		repeat (10) @(posedge i_clock);
		bus(1'b0, `RSPT_OFS_TSTAT, 32'h0000_0000);
		check("gpio disabled", q[10], 1'b0);
		i_gpio <= 12'h000;
		bus(1'b1, `RSPT_OFS_PWRCTL, 32'h0000_0000);
		repeat (5) @(posedge i_clock);
		check("osc off", o_slow_osc_enable, 1'b0);
		rspt_button_inst.press(1'b1);
		repeat (10) @(posedge i_clock);
		check("osc forced", o_slow_osc_enable, 1'b1);
		check("pad trim", o_slow_osc_default_trim, 1'b1);
		expect_rst(3'b100, 40000);
		check("delay", n > 32740 && n < 32800, 1'b1);
		quiet(300);
		rd(`RSPT_OFS_TSTAT, 32'h0000_0A00, "pad lock");
		rd(`RSPT_OFS_TIMER, 8'h18, "factor reset");
		rd(`RSPT_OFS_STAT, 8'h01, "cause");
		rspt_button_inst.press(1'b0);
		quiet(60);
		bus(1'b1, `RSPT_OFS_TIMER, 32'h0000_0001);
		bus(1'b1, `RSPT_OFS_PIN, 32'h0000_0013);
		i_gpio <= 12'h008;
		repeat (16000) @(posedge i_clock);
		rspt_button_inst.press(1'b1);
		repeat (100) @(posedge i_clock);
		i_gpio <= 12'h000;
		expect_rst(3'b100, 20000);
		rspt_button_inst.press(1'b0);
		complete_run;
	end
endmodule
